// file: src/bspf_pin_select.sv
// Function
// - The core clock comes from the PLL when the clock source select is low, else from the external clock.
// - Running from the external clock slows the core, so a reduced feature flag is raised.
// - The external memory interface exists only when a serial host mode is selected.
// - In serial modes the autoboot select level on the shared interrupt pin is sampled at reset release.
// - With autoboot select low the block fetches its own code over the address/data bus.
// - Once running, the shared pin is an open-drain active-low request while a message is pending.
// - In parallel modes the twelve multi-function pins carry the byte-wide host port.
// - In serial modes those pins serve the memory interface or firmware special use.
// - After reset all multi-function pins are high-impedance inputs.
// - Levels on certain multi-function pins at reset release choose the host mode.
// - In the two-wire serial mode the control data line is driven open drain.
// - Read, write and style straps decode 111 and 110 to parallel, 01x to two-wire, 10x to SPI.
// - With the external clock the core runs at a quarter rate until boot ends, then full rate.
`timescale 1ns/1ns
`include "bspf_params.svh"
module bspf_pin_select (
   input wire logic clk, // Core clock, 25 MHz
   input wire logic rst, // Async reset, active high
   input wire logic clock_source_select, // Strap: high selects external clock
   input wire logic ext_clock_in, // External clock pin level
   input wire logic [11:0] mf_pin_in, // Multi-function pin levels
   output logic [11:0] mf_pin_out, // Multi-function pin drive values
   output logic [11:0] mf_pin_oe_n, // Low while driving the pin
   input wire logic host_irq_n_in, // Shared pin level, autoboot select at reset
   output logic host_irq_n_out, // Shared pin drive value
   output logic host_irq_n_oe_n, // Low while pulling the pin low
   input wire logic serial_ctrl_data_io_in, // Serial data line level
   output logic serial_ctrl_data_io_out, // Serial data drive value
   output logic serial_ctrl_data_io_oe_n, // Low while driving the data line
   input wire logic ser_tx_bit, // Serial engine output bit
   input wire logic ser_tx_en, // Serial engine wants the line
   output logic ser_rx_bit, // Synchronised serial data level
   input wire logic code_loaded, // Host download finished
   input wire logic msg_pending, // Outgoing message waiting
   input wire logic [7:0] par_out, // Parallel port read data
   input wire logic par_drive, // Parallel port drives data pins
   input wire logic fw_gpio_en, // Firmware owns the pins in serial mode
   input wire logic [11:0] fw_gpio_out, // Firmware pin values
   input wire logic [11:0] fw_gpio_drive, // Firmware pin drive enables
   output logic [11:0] mf_pin_rx, // Synchronised pin levels
   output bspf_pkg::bspf_host_mode_t host_mode, // Latched host mode
   output logic autoboot_active, // Self-load in progress
   output logic boot_done, // Code loaded and running
   output logic ext_mem_enabled, // Memory interface available
   output logic parallel_port_enabled, // Pins carry host port
   output logic core_clk_from_ext, // Core clocked from external pin
   output logic core_clk_div4, // Quarter-rate core clock in force
   output logic reduced_features, // Slow core, some features absent
   output logic dsp_core_clock, // Core clock tick pulse
   output logic [7:0] boot_data, // Byte fetched during autoboot
   output logic boot_data_valid // Fetched byte pulse
);

   typedef enum logic [1:0] {ST_SETTLE, ST_HOST_LOAD, ST_AUTOBOOT, ST_RUN} bspf_boot_t;

   // Strap decode, shared by the latch and its check
   function automatic bspf_pkg::bspf_host_mode_t decode_mode(input logic rd,
                                                             input logic wr,
                                                             input logic psel);
      if (rd && wr) begin
         decode_mode = psel ? bspf_pkg::BSPF_HOST_PAR_M : bspf_pkg::BSPF_HOST_PAR_I;
      end else if (!rd && wr) begin
         decode_mode = bspf_pkg::BSPF_HOST_I2C;
      end else begin
         decode_mode = bspf_pkg::BSPF_HOST_SPI;
      end
   endfunction : decode_mode

   ////////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic [11:0] mf_s;
   logic ext_clk_s;
   logic clk_sel_s;
   logic irq_s;
   logic sd_s;

   bspf_sync #(.W(16)) u_sync (
      .clk(clk),
      .rst(rst),
      .d({ext_clock_in, clock_source_select, host_irq_n_in, serial_ctrl_data_io_in,
          mf_pin_in}),
      .q({ext_clk_s, clk_sel_s, irq_s, sd_s, mf_s})
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Boot sequencing and strap latch

   bspf_boot_t state_q, state_d;
   logic [1:0] settle_q;
   bspf_pkg::bspf_host_mode_t mode_q;
   logic ext_clk_q;
   logic ext_mem_q;
   logic par_q;
   logic fetch_start_q;
   logic boot_done_q;
   logic f_done;

   // Capture once the synchronisers hold post-reset levels
   wire capture = (state_q == ST_SETTLE) && (settle_q == `BSPF_STRAP_SETTLE);
   wire bspf_pkg::bspf_host_mode_t mode_dec = decode_mode(mf_s[`BSPF_PIN_RD],
                                                           mf_s[`BSPF_PIN_WR],
                                                           mf_s[`BSPF_PIN_PSEL]);
   wire serial_dec = (mode_dec == bspf_pkg::BSPF_HOST_I2C) ||
                     (mode_dec == bspf_pkg::BSPF_HOST_SPI);
   wire autoboot_dec = serial_dec && !irq_s;
   wire serial = (mode_q == bspf_pkg::BSPF_HOST_I2C) || (mode_q == bspf_pkg::BSPF_HOST_SPI);
   wire i2c = (mode_q == bspf_pkg::BSPF_HOST_I2C);
   wire running = (state_q == ST_RUN);
   wire in_autoboot = (state_q == ST_AUTOBOOT);
   wire ctrl_live = (state_q != ST_SETTLE);

   // Host download waits on the host; autoboot waits on the fetcher
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_SETTLE: if (capture) state_d = autoboot_dec ? ST_AUTOBOOT : ST_HOST_LOAD;
         ST_HOST_LOAD: if (code_loaded) state_d = ST_RUN;
         ST_AUTOBOOT: if (f_done) state_d = ST_RUN;
         default: state_d = state_q;
      endcase
   end

   // Straps are written only at capture, so later pin changes are ignored
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_SETTLE;
         settle_q <= 2'h0;
         mode_q <= bspf_pkg::BSPF_HOST_SPI;
         ext_clk_q <= 1'b0;
         ext_mem_q <= 1'b0;
         par_q <= 1'b0;
         fetch_start_q <= 1'b0;
         boot_done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         settle_q <= (state_q == ST_SETTLE) ? settle_q + 2'h1 : settle_q;
         fetch_start_q <= capture && autoboot_dec;
         boot_done_q <= (state_d == ST_RUN);
         if (capture) begin
            mode_q <= mode_dec;
            ext_clk_q <= clk_sel_s;
            ext_mem_q <= serial_dec;
            par_q <= !serial_dec;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Self-loading fetch over the address/data bus

   logic [7:0] f_bus;
   logic f_drive;
   logic f_hi_stb;
   logic f_lo_stb;
   logic f_rd_n;

   bspf_boot_fetch u_fetch (
      .clk(clk),
      .rst(rst),
      .start(fetch_start_q),
      .bus_in(mf_s[7:0]),
      .bus_out(f_bus),
      .bus_drive(f_drive),
      .addr_hi_stb(f_hi_stb),
      .addr_lo_stb(f_lo_stb),
      .mem_rd_n(f_rd_n),
      .load_data(boot_data),
      .load_valid(boot_data_valid),
      .done(f_done)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Core clock selection and rate

   logic ext_prev_q;
   logic [1:0] div_q;
   logic tick_q;
   logic div4_q;

   wire ext_rise = ext_clk_s && !ext_prev_q;
   // Quarter rate before boot ends, every external edge after
   wire ext_tick = ext_rise && (boot_done_q || (div_q == 2'h3));
   // PLL path is modelled as a tick on every core cycle outside ST_SETTLE
   wire tick_d = ext_clk_q ? ext_tick : ctrl_live;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ext_prev_q <= 1'b0;
         div_q <= 2'h0;
         tick_q <= 1'b0;
         div4_q <= 1'b0;
      end else begin
         ext_prev_q <= ext_clk_s;
         div_q <= ext_rise ? div_q + 2'h1 : div_q;
         tick_q <= tick_d;
         div4_q <= ext_clk_q && !boot_done_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Pin ownership

   // Hi-Z until the mode is known; autoboot owns the bus while loading
   wire par_live = ctrl_live && !serial;
   wire [11:0] mf_out_d = in_autoboot ? {1'b0, f_rd_n, f_lo_stb, f_hi_stb, f_bus} :
                          par_live ? {4'h0, par_out} : fw_gpio_out;
   wire [11:0] mf_oe_n_d = in_autoboot ? {4'h8, {8{!f_drive}}} :
                           par_live ? {4'hf, {8{!par_drive}}} :
                           (running && fw_gpio_en) ? ~fw_gpio_drive :
                           `BSPF_PINS_HIZ;
   // Two-wire mode only ever pulls low; SPI drives both levels
   wire sd_out_d = i2c ? 1'b0 : ser_tx_bit;
   wire sd_oe_n_d = !(ctrl_live && serial) ? 1'b1 :
                    i2c ? !(ser_tx_en && !ser_tx_bit) : !ser_tx_en;
   // Strap pin turns into the message request only after boot
   wire irq_oe_n_d = !(running && msg_pending);

   logic [11:0] mf_out_q;
   logic [11:0] mf_oe_n_q;
   logic sd_out_q;
   logic sd_oe_n_q;
   logic irq_oe_n_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mf_out_q <= 12'h000;
         mf_oe_n_q <= `BSPF_PINS_HIZ;
         sd_out_q <= 1'b0;
         sd_oe_n_q <= 1'b1;
         irq_oe_n_q <= 1'b1;
      end else begin
         mf_out_q <= mf_out_d;
         mf_oe_n_q <= mf_oe_n_d;
         sd_out_q <= sd_out_d;
         sd_oe_n_q <= sd_oe_n_d;
         irq_oe_n_q <= irq_oe_n_d;
      end
   end

   // Outputs
   assign mf_pin_out = mf_out_q;
   assign mf_pin_oe_n = mf_oe_n_q;
   assign mf_pin_rx = mf_s;
   assign host_irq_n_out = 1'b0;
   assign host_irq_n_oe_n = irq_oe_n_q;
   assign serial_ctrl_data_io_out = sd_out_q;
   assign serial_ctrl_data_io_oe_n = sd_oe_n_q;
   assign ser_rx_bit = sd_s;
   assign host_mode = mode_q;
   assign autoboot_active = in_autoboot;
   assign boot_done = boot_done_q;
   assign ext_mem_enabled = ext_mem_q;
   assign parallel_port_enabled = par_q;
   assign core_clk_from_ext = ext_clk_q;
   assign core_clk_div4 = div4_q;
   assign reduced_features = ext_clk_q;
   assign dsp_core_clock = tick_q;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_auto_strap;
      capture && serial_dec && !irq_s;
   endsequence

   sequence s_auto_start;
      (state_q == ST_AUTOBOOT) && fetch_start_q ##1 (state_q == ST_AUTOBOOT) && !fetch_start_q;
   endsequence

   a_autoboot_entry: assert property (s_auto_strap |=> s_auto_start)
      else $error("autoboot not entered after low strap");
   a_host_download: assert property (capture && !autoboot_dec |=> state_q == ST_HOST_LOAD)
      else $error("host download not awaited");
   a_mode_decode: assert property (capture |=> mode_q == decode_mode($past(mf_s[`BSPF_PIN_RD]),
      $past(mf_s[`BSPF_PIN_WR]), $past(mf_s[`BSPF_PIN_PSEL])))
      else $error("host mode decode wrong");
   a_strap_hold: assert property (!$past(state_q == ST_SETTLE) |->
      $stable(mode_q) && $stable(ext_clk_q) && $stable(ext_mem_q))
      else $error("strap selection changed after capture");
   a_clock_source: assert property (capture |=> core_clk_from_ext == $past(clk_sel_s))
      else $error("clock source not taken from strap");
   a_quarter_rate: assert property (ext_clk_q && !boot_done_q && ext_rise && div_q != 2'h3
      |=> !dsp_core_clock)
      else $error("full rate tick before boot end");
   a_full_rate: assert property (ext_clk_q && boot_done_q && ext_rise |=> dsp_core_clock)
      else $error("missing tick after boot");
   a_mem_serial: assert property (ext_mem_enabled |-> serial)
      else $error("memory interface in parallel mode");
   a_pins_hiz: assert property (state_q == ST_SETTLE |=>
      mf_pin_oe_n == `BSPF_PINS_HIZ && serial_ctrl_data_io_oe_n && host_irq_n_oe_n)
      else $error("pin driven before mode known");
   a_irq_request: assert property (!host_irq_n_oe_n |-> $past(running && msg_pending))
      else $error("request asserted without pending message");
   a_i2c_open_drain: assert property (i2c && !serial_ctrl_data_io_oe_n |->
      !serial_ctrl_data_io_out)
      else $error("two-wire data line driven high");
   a_par_port: assert property (par_live && par_drive |=>
      mf_pin_out[7:0] == $past(par_out) && mf_pin_oe_n[7:0] == 8'h00)
      else $error("parallel port data not on pins");

endmodule : bspf_pin_select

// file: shared/bspf_params.svh
`ifndef BSPF_PARAMS_SVH
`define BSPF_PARAMS_SVH

// Clock period and strap settling
`define BSPF_CLK_NS 40
`define BSPF_STRAP_SETTLE 2'h2

// Multi-function pin positions of the mode straps
`define BSPF_PIN_RD 8
`define BSPF_PIN_WR 9
`define BSPF_PIN_PSEL 10

// Multi-function pin positions of the boot memory strobes
`define BSPF_PIN_ADDR_HI 8
`define BSPF_PIN_ADDR_LO 9
`define BSPF_PIN_MEM_RD_N 10

// Boot memory access time and read wait derived from it
`define BSPF_MEM_READ_NS 200
`define BSPF_MEM_CYC ((`BSPF_MEM_READ_NS + `BSPF_CLK_NS - 1) / `BSPF_CLK_NS)
// Extra cycles: output register plus two synchroniser stages
`define BSPF_READ_WAIT (`BSPF_MEM_CYC + 3)

// Length of the self-loaded boot image in bytes
`define BSPF_BOOT_BYTES 16'h0400

// Reset values
`define BSPF_PINS_HIZ 12'hfff
`define BSPF_ADDR_RESET 16'h0000

`endif

// file: shared/bspf_pkg.sv
package bspf_pkg;

   // Host communication mode chosen by the straps
   typedef enum logic [1:0] {
      BSPF_HOST_PAR_M,
      BSPF_HOST_PAR_I,
      BSPF_HOST_I2C,
      BSPF_HOST_SPI
   } bspf_host_mode_t;

endpackage : bspf_pkg

// file: src/bspf_sync.sv
`timescale 1ns/1ns
module bspf_sync #(
   parameter int W = 1
) (
   input wire logic clk, // Core clock
   input wire logic rst, // Async reset, active high
   input wire logic [W-1:0] d, // Asynchronous levels
   output logic [W-1:0] q // Synchronised levels
);

   // Two stages per bit; the first stage feeds only the second
   generate
      for (genvar i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         logic sync_q;
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               meta_q <= 1'b0;
               sync_q <= 1'b0;
            end else begin
               meta_q <= d[i];
               sync_q <= meta_q;
            end
         end
         assign q[i] = sync_q;
      end
   endgenerate

endmodule : bspf_sync

// file: src/bspf_boot_fetch.sv
`timescale 1ns/1ns
`include "bspf_params.svh"
module bspf_boot_fetch (
   input wire logic clk, // Core clock
   input wire logic rst, // Async reset, active high
   input wire logic start, // One-cycle start pulse
   input wire logic [7:0] bus_in, // Synchronised memory data
   output logic [7:0] bus_out, // Address byte to drive
   output logic bus_drive, // Drive the address/data bus
   output logic addr_hi_stb, // High address byte strobe
   output logic addr_lo_stb, // Low address byte strobe
   output logic mem_rd_n, // Memory read strobe, active low
   output logic [7:0] load_data, // Byte read from memory
   output logic load_valid, // Byte valid pulse
   output logic done // Whole image loaded
);

   typedef enum logic [2:0] {F_IDLE, F_ADDR_HI, F_ADDR_LO, F_READ, F_DONE} bspf_fetch_t;

   localparam logic [3:0] READ_LAST = 4'(`BSPF_READ_WAIT - 1);
   localparam logic [15:0] ADDR_LAST = 16'(`BSPF_BOOT_BYTES - 16'h0001);

   bspf_fetch_t state_q, state_d;
   logic [15:0] addr_q;
   logic [3:0] wait_q;
   logic [7:0] data_q;
   logic valid_q;

   wire read_end = (state_q == F_READ) && (wait_q == READ_LAST);
   wire last_byte = (addr_q == ADDR_LAST);

   // Bus phase outputs; the caller registers them onto the pins
   assign bus_out = (state_q == F_ADDR_HI) ? addr_q[15:8] : addr_q[7:0];
   assign bus_drive = (state_q == F_ADDR_HI) || (state_q == F_ADDR_LO);
   assign addr_hi_stb = (state_q == F_ADDR_HI);
   assign addr_lo_stb = (state_q == F_ADDR_LO);
   assign mem_rd_n = !(state_q == F_READ);
   assign load_data = data_q;
   assign load_valid = valid_q;
   assign done = (state_q == F_DONE);

   // Address, read, next address until the image is in
   always_comb begin
      state_d = state_q;
      case (state_q)
         F_IDLE: if (start) state_d = F_ADDR_HI;
         F_ADDR_HI: state_d = F_ADDR_LO;
         F_ADDR_LO: state_d = F_READ;
         F_READ: if (read_end) state_d = last_byte ? F_DONE : F_ADDR_HI;
         default: state_d = state_q;
      endcase
   end

   // Wait counter covers pin register, memory access and synchroniser
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= F_IDLE;
         addr_q <= `BSPF_ADDR_RESET;
         wait_q <= 4'h0;
         data_q <= 8'h00;
         valid_q <= 1'b0;
      end else begin
         state_q <= state_d;
         wait_q <= (state_q == F_READ && !read_end) ? wait_q + 4'h1 : 4'h0;
         valid_q <= read_end;
         if (read_end) begin
            data_q <= bus_in;
            addr_q <= addr_q + 16'h0001;
         end
      end
   end

endmodule : bspf_boot_fetch

// file: bench/bspf_mem_host_model.sv
`timescale 1ns/1ns
module bspf_mem_host_model #(
   parameter int LAT = 1
) (
   input wire logic clk, // Core clock
   input wire logic [11:0] mf_pin_out, // Block pin values
   input wire logic [11:0] mf_pin_oe_n, // Block enables, low drives
   input wire logic [11:0] term_level, // Resistor or strap level
   input wire logic host_irq_n_oe_n, // Block pulls request low
   input wire logic irq_term, // Level on shared pin when released
   output logic [11:0] pin_level, // Resolved pin levels
   output logic irq_level // Resolved shared pin level
);
   logic [15:0] addr_q;
   logic [3:0] wait_q;
   logic rd_act;
   logic [7:0] mem_byte;
   logic [7:0] mem_data;
   logic [11:0] ext_drv;
   ////////////////////////////////////////////////////////////////
   // Memory latches both address bytes from the strobe pins
   always_ff @(posedge clk) begin
      if (pin_level[8] === 1'b1) addr_q[15:8] <= pin_level[7:0];
      if (pin_level[9] === 1'b1) addr_q[7:0] <= pin_level[7:0];
      wait_q <= rd_act ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
   end
   ////////////////////////////////////////////////////////////////
   // Slow memory shows the inverse until its access time is over
   assign rd_act = !mf_pin_oe_n[10] && !mf_pin_out[10];
   assign mem_byte = addr_q[7:0] ^ addr_q[15:8] ^ 8'ha5;
   assign mem_data = (wait_q >= LAT) ? mem_byte : ~mem_byte;
   assign ext_drv = rd_act ? {term_level[11:8], mem_data} : term_level;
   // Released pins fall back to their termination
   assign pin_level = (~mf_pin_oe_n & mf_pin_out) | (mf_pin_oe_n & ext_drv);
   assign irq_level = host_irq_n_oe_n ? irq_term : 1'b0;
endmodule : bspf_mem_host_model

// file: bench/tb_boot_strap_pin_function_select.sv
`timescale 1ns/1ns
module tb_boot_strap_pin_function_select;
   logic clk, rst, clock_source_select, ext_clock_in, irq_term, irq_level;
   logic [11:0] term_level, pin_level, mf_pin_out, mf_pin_oe_n, fw_gpio_out, fw_gpio_drive;
   logic host_irq_n_out, host_irq_n_oe_n, sda_level, sda_out, sda_oe_n;
   logic ser_tx_bit, ser_tx_en, ser_rx_bit, code_loaded, msg_pending, par_drive, fw_gpio_en;
   logic [7:0] par_out, boot_data;
   logic [11:0] mf_pin_rx;
   bspf_pkg::bspf_host_mode_t host_mode;
   logic autoboot_active, boot_done, ext_mem_enabled, parallel_port_enabled, boot_data_valid;
   logic core_clk_from_ext, core_clk_div4, reduced_features, dsp_core_clock;
   int err_total, num_checks, cyc, tick_cnt;
   ////////////////////////////////////////////////////////////////
   bspf_pin_select dut_u (.clk(clk), .rst(rst), .clock_source_select(clock_source_select),
      .ext_clock_in(ext_clock_in), .mf_pin_in(pin_level), .mf_pin_out(mf_pin_out),
      .mf_pin_oe_n(mf_pin_oe_n), .host_irq_n_in(irq_level), .host_irq_n_out(host_irq_n_out),
      .host_irq_n_oe_n(host_irq_n_oe_n), .serial_ctrl_data_io_in(sda_level),
      .serial_ctrl_data_io_out(sda_out), .serial_ctrl_data_io_oe_n(sda_oe_n),
      .ser_tx_bit(ser_tx_bit), .ser_tx_en(ser_tx_en), .ser_rx_bit(ser_rx_bit),
      .code_loaded(code_loaded), .msg_pending(msg_pending), .par_out(par_out),
      .par_drive(par_drive), .fw_gpio_en(fw_gpio_en), .fw_gpio_out(fw_gpio_out),
      .fw_gpio_drive(fw_gpio_drive), .mf_pin_rx(mf_pin_rx), .host_mode(host_mode),
      .autoboot_active(autoboot_active), .boot_done(boot_done),
      .ext_mem_enabled(ext_mem_enabled), .parallel_port_enabled(parallel_port_enabled),
      .core_clk_from_ext(core_clk_from_ext), .core_clk_div4(core_clk_div4),
      .reduced_features(reduced_features), .dsp_core_clock(dsp_core_clock),
      .boot_data(boot_data), .boot_data_valid(boot_data_valid));
   bspf_mem_host_model #(.LAT(1)) mem_u (.clk(clk), .mf_pin_out(mf_pin_out),
      .mf_pin_oe_n(mf_pin_oe_n), .term_level(term_level), .host_irq_n_oe_n(host_irq_n_oe_n),
      .irq_term(irq_term), .pin_level(pin_level), .irq_level(irq_level));
   // Two-wire data line has a pull-up
   assign sda_level = sda_oe_n ? 1'b1 : sda_out;
   ////////////////////////////////////////////////////////////////
   // Clock, external clock at half rate, tick counter and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      ext_clock_in <= #1 ~ext_clock_in;
      tick_cnt <= tick_cnt + (dsp_core_clock === 1'b1);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_total++;
         $display("[FAIL] %0t watchdog expired", $time);
         close_out();
      end
   end
   ////////////////////////////////////////////////////////////////
   task automatic close_out;
      $display("Counts: %0d checks, %0d mismatches", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   task automatic check(input logic ok, input string what);
      num_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : check
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc
   // Straps rwp = {rd, wr, psel} sit on pins 8, 9, 10
   task automatic do_reset(input logic [2:0] rwp, input logic abt, input logic csel);
      rst = 1'b1;
      term_level = {1'b1, rwp[0], rwp[1], rwp[2], 8'hff};
      irq_term = abt;
      clock_source_select = csel;
      wait_cyc(8);
      check(mf_pin_oe_n === 12'hfff && host_irq_n_oe_n === 1'b1, "pins in reset");
      rst = 1'b0;
      wait_cyc(5);
   endtask : do_reset
   ////////////////////////////////////////////////////////////////
   task automatic t_modes;
      logic [2:0] codes [6] = '{3'b111, 3'b110, 3'b010, 3'b011, 3'b100, 3'b101};
      bspf_pkg::bspf_host_mode_t exp [6] = '{bspf_pkg::BSPF_HOST_PAR_M,
         bspf_pkg::BSPF_HOST_PAR_I, bspf_pkg::BSPF_HOST_I2C, bspf_pkg::BSPF_HOST_I2C,
         bspf_pkg::BSPF_HOST_SPI, bspf_pkg::BSPF_HOST_SPI};
      for (int i = 0; i < 6; i++) begin
         // Parallel modes strap the shared pin low: still no self-load
         do_reset(codes[i], i >= 2, 1'b0);
         check(host_mode === exp[i], "mode decode");
         check(parallel_port_enabled === (i < 2), "parallel port flag");
         check(ext_mem_enabled === (i >= 2), "memory interface flag");
         check(autoboot_active === 1'b0, "no self-load");
         check(dsp_core_clock === 1'b1 && reduced_features === 1'b0, "pll core");
      end
      $display("test modes done");
   endtask : t_modes
   task automatic t_par;
      do_reset(3'b110, 1'b1, 1'b0);
      term_level = 12'hdff;
      wait_cyc(10);
      check(host_mode === bspf_pkg::BSPF_HOST_PAR_I, "straps held");
      check(mf_pin_oe_n === 12'hfff, "idle pins released");
      check(mf_pin_rx === 12'hdff, "released pins read back");
      par_out = 8'h3c;
      par_drive = 1'b1;
      wait_cyc(2);
      check(mf_pin_oe_n[7:0] === 8'h00 && pin_level[7:0] === 8'h3c, "host port");
      par_drive = 1'b0;
      wait_cyc(2);
      check(mf_pin_oe_n[7:0] === 8'hff, "host port released");
      $display("test parallel done");
   endtask : t_par
   task automatic t_host_load;
      do_reset(3'b100, 1'b1, 1'b0);
      wait_cyc(20);
      check(boot_done === 1'b0 && mf_pin_oe_n === 12'hfff, "waits for download");
      code_loaded = 1'b1;
      wait_cyc(1);
      code_loaded = 1'b0;
      wait_cyc(1);
      check(boot_done === 1'b1 && irq_level === 1'b1, "running, no request");
      fw_gpio_out = 12'ha5c;
      fw_gpio_drive = 12'h0ff;
      fw_gpio_en = 1'b1;
      wait_cyc(2);
      check(mf_pin_oe_n === 12'hf00 && pin_level[7:0] === 8'h5c, "firmware pins");
      msg_pending = 1'b1;
      wait_cyc(1);
      check(irq_level === 1'b0 && host_irq_n_out === 1'b0, "request raised");
      // Host sees the request and reads the message out
      if (irq_level === 1'b0) msg_pending = 1'b0;
      wait_cyc(1);
      check(irq_level === 1'b1, "request released");
      fw_gpio_en = 1'b0;
      $display("test host load done");
   endtask : t_host_load
   task automatic t_i2c;
      do_reset(3'b010, 1'b1, 1'b0);
      ser_tx_en = 1'b1;
      ser_tx_bit = 1'b0;
      wait_cyc(1);
      check(sda_oe_n === 1'b0 && sda_level === 1'b0, "drive low");
      ser_tx_bit = 1'b1;
      wait_cyc(1);
      check(sda_oe_n === 1'b1 && sda_level === 1'b1, "open drain high");
      wait_cyc(2);
      check(ser_rx_bit === 1'b1, "line read back");
      ser_tx_en = 1'b0;
      $display("test two-wire done");
   endtask : t_i2c
   task automatic t_autoboot;
      int n, t0, c0;
      logic [15:0] a;
      do_reset(3'b101, 1'b0, 1'b1);
      irq_term = 1'b1;
      check(autoboot_active === 1'b1 && ext_mem_enabled === 1'b1, "self-load");
      check(core_clk_from_ext === 1'b1 && reduced_features === 1'b1, "ext core");
      check(core_clk_div4 === 1'b1, "quarter rate in boot");
      t0 = tick_cnt;
      c0 = cyc;
      for (int k = 0; k < 1024; k++) begin
         n = 0;
         a = k[15:0];
         while (boot_data_valid !== 1'b1 && n < 20) begin
            wait_cyc(1);
            n++;
         end
         check(boot_data === (a[7:0] ^ a[15:8] ^ 8'ha5), "boot byte");
         wait_cyc(1);
      end
      // One tick per four external edges, edges every second cycle
      check((tick_cnt - t0) * 8 >= cyc - c0 - 16, "slow ticks low");
      check((tick_cnt - t0) * 8 <= cyc - c0 + 16, "slow ticks high");
      wait_cyc(4);
      check(boot_done === 1'b1 && autoboot_active === 1'b0, "boot ended");
      check(core_clk_div4 === 1'b0 && mf_pin_oe_n === 12'hfff, "full rate");
      t0 = tick_cnt;
      wait_cyc(64);
      check(tick_cnt - t0 >= 31 && tick_cnt - t0 <= 33, "fast ticks");
      $display("test autoboot done");
   endtask : t_autoboot
   ////////////////////////////////////////////////////////////////
   initial begin
      rst = 1'b1;
      ext_clock_in = 1'b0;
      clock_source_select = 1'b0;
      term_level = 12'hfff;
      irq_term = 1'b1;
      ser_tx_bit = 1'b1;
      ser_tx_en = 1'b0;
      code_loaded = 1'b0;
      msg_pending = 1'b0;
      par_out = 8'h00;
      par_drive = 1'b0;
      fw_gpio_en = 1'b0;
      fw_gpio_out = 12'h000;
      fw_gpio_drive = 12'h000;
      err_total = 0;
      num_checks = 0;
      cyc = 0;
      tick_cnt = 0;
      @(posedge clk);
      #1;
      t_modes();
      t_par();
      t_host_load();
      t_i2c();
      t_autoboot();
      close_out();
   end
endmodule : tb_boot_strap_pin_function_select
